// ### vscp_top.sv
// Purpose: Serial control port and configuration registers of a dual VGA
// Assumes: Host obeys frame timing; select high long enough between frames
// Notes: Gain decode tables and analogue stages live outside this block
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
module vscp_top (
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  input wire logic SCK_I,
  input wire logic SELECT_LOW_B_I,
  input wire logic SDI_I,
  input wire logic [6:0] PARALLEL_GAIN_CODE_I,
  output logic SDO_O,
  output logic SDO_OE_O,
  output logic CH_I_ENABLE_O,
  output logic CH_Q_ENABLE_O,
  output logic [1:0] AMP_BIAS_O,
  output logic [1:0] DRV_BIAS_O,
  output logic LOW_INPUT_IMPEDANCE_SEL_O,
  output logic GAIN_FROM_SERIAL_O,
  output logic GAIN_DECODE_BYPASS_O,
  output logic DEGLITCH_BYPASS_O,
  output logic [8:0] STAGE_GAIN_CODE_O
);
  logic sel_s1_r;
  logic sel_s2_r;
  logic sel_s3_r;
  logic [vscp_pkg::PGAIN_W-1:0] gc_s1_r;
  logic [vscp_pkg::PGAIN_W-1:0] gc_s2_r;
  logic [vscp_pkg::DATA_W-1:0] rdaddr_r;
  logic [vscp_pkg::DATA_W-1:0] rdaddr_nxt;
  logic [vscp_pkg::EN_W-1:0] enable_r;
  logic [vscp_pkg::EN_W-1:0] enable_nxt;
  logic [vscp_pkg::SET_W-1:0] settings_r;
  logic [vscp_pkg::SET_W-1:0] settings_nxt;
  logic [vscp_pkg::GAIN_W-1:0] gain_r;
  logic [vscp_pkg::GAIN_W-1:0] gain_nxt;
  vscp_pkg::vscp_sr_e sr_r;
  vscp_pkg::vscp_sr_e sr_nxt;
  logic addressed_r;
  logic addressed_nxt;
  logic [vscp_pkg::FRAME_W-1:0] rd_word_r;
  logic [vscp_pkg::FRAME_W-1:0] rd_word_nxt;
  logic [vscp_pkg::GAIN_W-1:0] prev_code_r;
  logic [vscp_pkg::GAIN_W-1:0] gout_r;
  logic [vscp_pkg::GAIN_W-1:0] gout_nxt;
  logic byp_r;
  typedef logic [vscp_pkg::DATA_W-1:0] vscp_word_t;
  typedef logic [vscp_pkg::GAIN_W-1:0] vscp_gain_t;

  wire frame_end;
  wire [vscp_pkg::CHIP_W-1:0] rx_chip;
  wire [vscp_pkg::RADDR_W-1:0] rx_addr;
  wire [vscp_pkg::DATA_W-1:0] rx_data;
  wire wr_ok;
  wire wr_rd;
  wire wr_en;
  wire wr_set;
  wire wr_gain;
  wire soft_fire;
  wire [vscp_pkg::RADDR_W-1:0] rd_idx;
  wire [vscp_pkg::DATA_W-1:0] rd_data;
  wire src;
  wire dec_byp;
  wire dgl_byp;
  wire [vscp_pkg::GAIN_W-1:0] ser_code;
  wire [vscp_pkg::GAIN_W-1:0] par_code;
  wire [vscp_pkg::GAIN_W-1:0] sel_code;
  wire steady;

  vscp_link_if lnk ();

  vscp_shift u_shift (
    .sck_i(SCK_I),
    .sel_b_i(SELECT_LOW_B_I),
    .sdi_i(SDI_I),
    .lnk(lnk)
  );

  ////////////////////////////////////////////////////////////////////////
  // Select and gain pins cross into the system clock
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_B_I)
    begin
      sel_s1_r <= 1'b1;
      sel_s2_r <= 1'b1;
      sel_s3_r <= 1'b1;
      gc_s1_r <= '0;
      gc_s2_r <= '0;
    end
    else
    begin
      sel_s1_r <= SELECT_LOW_B_I;
      sel_s2_r <= sel_s1_r;
      sel_s3_r <= sel_s2_r;
      gc_s1_r <= PARALLEL_GAIN_CODE_I;
      gc_s2_r <= gc_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame decode; shifter word is still once select is seen high
  assign frame_end = sel_s2_r && !sel_s3_r;
  assign rx_chip = lnk.rx_word[vscp_pkg::CHIP_LSB +: vscp_pkg::CHIP_W];
  assign rx_addr = lnk.rx_word[vscp_pkg::RADDR_LSB +: vscp_pkg::RADDR_W];
  assign rx_data = lnk.rx_word[vscp_pkg::DATA_LSB +: vscp_pkg::DATA_W];
  // Short or long frames and other chips write no register, but they clear addressed_r
  assign wr_ok = frame_end && lnk.rx_full &&
    (rx_chip == vscp_pkg::CHIP_ADDR);
  assign wr_rd = wr_ok && (rx_addr == vscp_pkg::REG_RDADDR);
  assign wr_en = wr_ok && (rx_addr == vscp_pkg::REG_ENABLE);
  assign wr_set = wr_ok && (rx_addr == vscp_pkg::REG_SETTINGS);
  assign wr_gain = wr_ok && (rx_addr == vscp_pkg::REG_GAIN);
  assign soft_fire = wr_rd && (sr_r == vscp_pkg::SR_ARMED) &&
    (rx_data == vscp_pkg::SOFT_FIRE);

  // Every completed frame to this chip is a write, read frames included
  assign rdaddr_nxt = soft_fire ? vscp_pkg::RST_RDADDR :
    wr_rd ? rx_data : rdaddr_r;
  assign enable_nxt = soft_fire ? vscp_pkg::RST_ENABLE :
    wr_en ? rx_data[vscp_pkg::EN_W-1:0] : enable_r;
  assign settings_nxt = soft_fire ? vscp_pkg::RST_SETTINGS :
    wr_set ? rx_data[vscp_pkg::SET_W-1:0] : settings_r;
  assign gain_nxt = soft_fire ? vscp_pkg::RST_GAIN :
    wr_gain ? rx_data[vscp_pkg::GAIN_W-1:0] : gain_r;

  // Any other value to register 0 drops the armed state
  assign sr_nxt = !wr_rd ? sr_r :
    (rx_data == vscp_pkg::SOFT_ARM) ? vscp_pkg::SR_ARMED :
    vscp_pkg::SR_IDLE;
  assign addressed_nxt = frame_end ? wr_ok : addressed_r;

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_B_I)
    begin
      rdaddr_r <= vscp_pkg::RST_RDADDR;
      enable_r <= vscp_pkg::RST_ENABLE;
      settings_r <= vscp_pkg::RST_SETTINGS;
      gain_r <= vscp_pkg::RST_GAIN;
      sr_r <= vscp_pkg::SR_IDLE;
      addressed_r <= 1'b0;
    end
    else
    begin
      rdaddr_r <= rdaddr_nxt;
      enable_r <= enable_nxt;
      settings_r <= settings_nxt;
      gain_r <= gain_nxt;
      sr_r <= sr_nxt;
      addressed_r <= addressed_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read word; frozen while a frame runs so the shifter sees it still
  assign rd_idx = rdaddr_r[vscp_pkg::RADDR_W-1:0];
  assign rd_data =
    (rd_idx == vscp_pkg::REG_RDADDR) ? rdaddr_r :
    (rd_idx == vscp_pkg::REG_ENABLE) ?
      vscp_word_t'(enable_r & vscp_pkg::EN_READ_MASK) :
    (rd_idx == vscp_pkg::REG_SETTINGS) ? vscp_word_t'(settings_r) :
    (rd_idx == vscp_pkg::REG_GAIN) ? vscp_word_t'(gain_r) : '0;
  assign rd_word_nxt = sel_s2_r ?
    {rd_data, rd_idx, vscp_pkg::CHIP_ADDR} : rd_word_r;

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_B_I)
      rd_word_r <= '0;
    else
      rd_word_r <= rd_word_nxt;
  end

  assign lnk.rd_word = rd_word_r;
  assign lnk.addressed = addressed_r;

  ////////////////////////////////////////////////////////////////////////
  // Gain source, decode bypass and deglitch
  assign src = settings_r[vscp_pkg::SET_SRC];
  assign dec_byp = settings_r[vscp_pkg::SET_DEC];
  assign dgl_byp = settings_r[vscp_pkg::SET_DGL];
  assign ser_code = dec_byp ? gain_r :
    vscp_gain_t'(gain_r[vscp_pkg::DEC_GAIN_W-1:0]);
  assign par_code = vscp_gain_t'(gc_s2_r);
  assign sel_code = src ? ser_code : par_code;
  // One steady cycle swallows the allowed skew between pin edges
  assign steady = (sel_code == prev_code_r);
  assign gout_nxt = (dgl_byp || steady) ? sel_code : gout_r;

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_B_I)
    begin
      prev_code_r <= '0;
      gout_r <= '0;
      byp_r <= 1'b0;
    end
    else
    begin
      prev_code_r <= sel_code;
      gout_r <= gout_nxt;
      byp_r <= src && dec_byp;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign SDO_O = lnk.sdo;
  assign SDO_OE_O = lnk.sdo_oe;
  assign CH_I_ENABLE_O = enable_r[vscp_pkg::EN_I];
  assign CH_Q_ENABLE_O = enable_r[vscp_pkg::EN_I+1];
  assign AMP_BIAS_O = settings_r[vscp_pkg::SET_AMP +: 2];
  assign DRV_BIAS_O = settings_r[vscp_pkg::SET_DRV +: 2];
  assign LOW_INPUT_IMPEDANCE_SEL_O = settings_r[vscp_pkg::SET_RIN];
  assign GAIN_FROM_SERIAL_O = src;
  assign GAIN_DECODE_BYPASS_O = byp_r;
  assign DEGLITCH_BYPASS_O = dgl_byp;
  assign STAGE_GAIN_CODE_O = gout_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks, all on the system clock
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_B_I);

  sequence s_fire_write;
    sr_r == vscp_pkg::SR_ARMED && wr_rd && rx_data == vscp_pkg::SOFT_FIRE;
  endsequence
  sequence s_gain_frame;
    $rose(sel_s2_r) ##0 wr_gain;
  endsequence

  property p_gain_commit;
    s_gain_frame |=> gain_r == $past(rx_data[vscp_pkg::GAIN_W-1:0]);
  endproperty
  a_gain_commit: assert property (p_gain_commit)
    else $error("frame data not committed at select rise");

  property p_par_sync;
    $past(RST_B_I) && $past(RST_B_I, 2) |->
      gc_s2_r == $past(PARALLEL_GAIN_CODE_I, 2);
  endproperty
  a_par_sync: assert property (p_par_sync)
    else $error("parallel gain code not passed through two stages");

  property p_en_write;
    wr_en |=> {CH_Q_ENABLE_O, CH_I_ENABLE_O} == $past(rx_data[1:0]);
  endproperty
  a_en_write: assert property (p_en_write)
    else $error("channel enables do not follow register write");

  property p_en_reset;
    $rose(RST_B_I) |-> enable_r == vscp_pkg::RST_ENABLE;
  endproperty
  a_en_reset: assert property (p_en_reset)
    else $error("enable register reset value wrong");

  property p_set_reset;
    $rose(RST_B_I) |-> settings_r == vscp_pkg::RST_SETTINGS;
  endproperty
  a_set_reset: assert property (p_set_reset)
    else $error("settings register reset value wrong");

  property p_drv_write;
    wr_set |=> DRV_BIAS_O == $past(rx_data[3:2]);
  endproperty
  a_drv_write: assert property (p_drv_write)
    else $error("driver bias does not follow register write");

  property p_rin_soft;
    s_fire_write |=> LOW_INPUT_IMPEDANCE_SEL_O;
  endproperty
  a_rin_soft: assert property (p_rin_soft)
    else $error("input impedance select not restored by soft reset");

  property p_par_src;
    (!src && dgl_byp) ##1 (!src && dgl_byp) |->
      STAGE_GAIN_CODE_O == $past(par_code);
  endproperty
  a_par_src: assert property (p_par_src)
    else $error("parallel gain code not routed to stages");

  property p_dec_byp;
    !src |=> !GAIN_DECODE_BYPASS_O;
  endproperty
  a_dec_byp: assert property (p_dec_byp)
    else $error("decode bypass active without serial gain");

  property p_deglitch;
    (!dgl_byp && sel_code != prev_code_r) |=> $stable(gout_r);
  endproperty
  a_deglitch: assert property (p_deglitch)
    else $error("gain changed before code settled");

  property p_soft_rst;
    s_fire_write |=> enable_r == vscp_pkg::RST_ENABLE &&
      settings_r == vscp_pkg::RST_SETTINGS && gain_r == vscp_pkg::RST_GAIN;
  endproperty
  a_soft_rst: assert property (p_soft_rst)
    else $error("soft reset sequence did not restore defaults");

  property p_foreign;
    (frame_end && rx_chip != vscp_pkg::CHIP_ADDR) |=>
      $stable(settings_r) && !addressed_r;
  endproperty
  a_foreign: assert property (p_foreign)
    else $error("frame for another chip was taken");

  property p_unused_rd;
    (sel_s2_r && rd_idx == vscp_pkg::REG_ENABLE) |=>
      rd_word_r[31:10] == '0;
  endproperty
  a_unused_rd: assert property (p_unused_rd)
    else $error("spare or unused enable bits read nonzero");
endmodule
`default_nettype wire

// ### vscp_pkg.sv
// Purpose: Shared constants for the serial control port block
// Assumes: 32-bit frames, data MSB first, then address, then chip id
// Notes: Register widths hold only implemented bits, except the enable register, which also keeps two spare bits
package vscp_pkg;
  localparam int FRAME_W = 32;
  localparam int DATA_W = 24;
  localparam int RADDR_W = 5;
  localparam int CHIP_W = 3;
  localparam int CNT_W = 6;
  localparam int EN_W = 4;
  localparam int SET_W = 8;
  localparam int GAIN_W = 9;
  localparam int PGAIN_W = 7;
  localparam logic [5:0] FRAME_LEN = 6'h20;
  localparam logic [5:0] CNT_MAX = 6'h3f;
  localparam logic [5:0] CNT_ONE = 6'h01;
  localparam logic [2:0] CHIP_ADDR = 3'h6;
  // Frame field positions
  localparam int CHIP_LSB = 0;
  localparam int RADDR_LSB = 3;
  localparam int DATA_LSB = 8;
  // Register offsets
  localparam logic [4:0] REG_RDADDR = 5'h00;
  localparam logic [4:0] REG_ENABLE = 5'h01;
  localparam logic [4:0] REG_SETTINGS = 5'h02;
  localparam logic [4:0] REG_GAIN = 5'h03;
  // Reset values
  localparam logic [23:0] RST_RDADDR = 24'h000000;
  localparam logic [3:0] RST_ENABLE = 4'h3;
  localparam logic [7:0] RST_SETTINGS = 8'h15;
  localparam logic [8:0] RST_GAIN = 9'h000;
  localparam logic [3:0] EN_READ_MASK = 4'h3;
  // Soft reset sequence values
  localparam logic [23:0] SOFT_ARM = 24'h000020;
  localparam logic [23:0] SOFT_FIRE = 24'h000000;
  // Field positions
  localparam int EN_I = 0;
  localparam int SET_AMP = 0;
  localparam int SET_DRV = 2;
  localparam int SET_RIN = 4;
  localparam int SET_SRC = 5;
  localparam int SET_DEC = 6;
  localparam int SET_DGL = 7;
  localparam int DEC_GAIN_W = 7;
  typedef enum logic {SR_IDLE = 1'b0, SR_ARMED = 1'b1} vscp_sr_e;
endpackage

// ### vscp_link_if.sv
// Purpose: Carrier between the core and the serial-clock shifter
// Assumes: Words cross only while they are held still
// Notes: link side runs on the serial clock
`timescale 1ns/1ps
`default_nettype none
interface vscp_link_if;
  logic [vscp_pkg::FRAME_W-1:0] rd_word;
  logic addressed;
  logic [vscp_pkg::FRAME_W-1:0] rx_word;
  logic rx_full;
  logic sdo;
  logic sdo_oe;
  modport link (input rd_word, input addressed, output rx_word,
    output rx_full, output sdo, output sdo_oe);
  modport core (output rd_word, output addressed, input rx_word,
    input rx_full, input sdo, input sdo_oe);
endinterface
`default_nettype wire

// ### vscp_shift.sv
// Purpose: Serial-clock side of the control port: shift in, shift out
// Assumes: Select high between frames; core holds rd_word still
// Notes: Counter and shift word are kept after the frame for the core
`timescale 1ns/1ps
`default_nettype none
module vscp_shift (
  input wire logic sck_i,
  input wire logic sel_b_i,
  input wire logic sdi_i,
  vscp_link_if.link lnk
);
  logic first_r;
  logic oe_r;
  logic sdo_r;
  logic sdo_nxt;
  logic [vscp_pkg::CNT_W-1:0] cnt_r;
  logic [vscp_pkg::CNT_W-1:0] cnt_nxt;
  logic [vscp_pkg::CNT_W-1:0] pos;
  logic [vscp_pkg::FRAME_W-1:0] sh_r;

  ////////////////////////////////////////////////////////////////////////
  // Select high rearms the frame; clock may stand still meanwhile
  always_ff @(posedge sck_i or posedge sel_b_i)
  begin
    if (sel_b_i)
    begin
      first_r <= 1'b1;
      oe_r <= 1'b0;
    end
    else
    begin
      first_r <= 1'b0;
      oe_r <= lnk.addressed;
    end
  end

  assign pos = first_r ? '0 : cnt_r;
  assign cnt_nxt = (pos == vscp_pkg::CNT_MAX) ? pos : pos + vscp_pkg::CNT_ONE;
  // Bit 31 first: ~pos picks 31-pos
  assign sdo_nxt = (pos < vscp_pkg::FRAME_LEN) ?
    lnk.rd_word[~pos[4:0]] : 1'b0;

  // Gated so a shared clock outside our frame leaves the word intact
  always_ff @(posedge sck_i)
  begin
    if (!sel_b_i)
    begin
      cnt_r <= cnt_nxt;
      sh_r <= {sh_r[vscp_pkg::FRAME_W-2:0], sdi_i};
      sdo_r <= sdo_nxt;
    end
  end

  assign lnk.rx_word = sh_r;
  assign lnk.rx_full = (cnt_r == vscp_pkg::FRAME_LEN);
  assign lnk.sdo = sdo_r;
  assign lnk.sdo_oe = oe_r;

  ////////////////////////////////////////////////////////////////////////
  property p_sdo_bit;
    @(posedge sck_i) disable iff (sel_b_i)
    (!first_r && cnt_r <= vscp_pkg::FRAME_LEN) |->
      sdo_r == lnk.rd_word[5'(vscp_pkg::FRAME_LEN - cnt_r)];
  endproperty
  a_sdo_bit: assert property (p_sdo_bit)
    else $error("serial out bit does not match read word");

  property p_shift_in;
    @(posedge sck_i) disable iff (sel_b_i)
    !first_r |-> sh_r[0] == $past(sdi_i);
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("serial in bit not captured on rising edge");
endmodule
`default_nettype wire

// ### vscp_host_model.sv
// Purpose: Host controller model that masters the serial control link
// Assumes: Link clock of 125 ns made only inside frames, idle low
// Notes: Data changes on falling edges, read data sampled on falling edges
`timescale 1ns/1ps
`default_nettype none
module vscp_host_model (
  output var logic sck_o,
  output var logic sel_b_o,
  output var logic sdi_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_i
);
  localparam realtime HALF = 62.5;

  initial
  begin
    sck_o = 1'b0;
    sdi_o = 1'b0;
    // Select pulses once so the link side arms before any frame
    sel_b_o = 1'b0;
    #1;
    sel_b_o = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // One 32-bit frame; oe_all is low if any sample saw the pin undriven
  task automatic xfer(input logic [31:0] word, output logic [31:0] rd,
    output logic oe_all);
    oe_all = 1'b1;
    #3;
    sel_b_o = 1'b0;
    sdi_o = word[31];
    for (int i = 31; i >= 0; i--)
    begin
      #(HALF);
      sck_o = 1'b1;
      #(HALF);
      sck_o = 1'b0;
      rd[i] = sdo_i;
      oe_all = oe_all & sdo_oe_i;
      if (i > 0)
        sdi_o = word[i-1];
    end
    // Rise before the next rising edge would come
    #(HALF / 2);
    sel_b_o = 1'b1;
    // Released line must not keep its last value
    sdi_o = ~sdi_o;
    #200;
  endtask
endmodule
`default_nettype wire

// ### vscp_tb.sv
// Purpose: Self-checking bench for the serial control port block
// Assumes: Host model owns the link pins; bench owns reset and gain pins
// Notes: Every register access is a full 32-bit link frame
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk;
  logic rst_b;
  logic [6:0] pgain;
  logic sck;
  logic sel_b;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  wire sdo_line;
  logic ch_i;
  logic ch_q;
  logic [1:0] amp;
  logic [1:0] drv;
  logic lowz;
  logic src;
  logic dec;
  logic dgl;
  logic [8:0] stage;
  logic [7:0] cfg;
  logic [31:0] w;
  logic oe;
  logic [7:0] set_tbl [4] = '{8'h00, 8'hff, 8'h4a, 8'ha5};
  int bad_count = 0;
  int samples_checked = 0;

  assign sdo_line = sdo_oe ? sdo : 1'bz;
  assign cfg = {dgl, dec, src, lowz, drv, amp};

  initial
  begin
    mclk = 1'b0;
  end
  always #5 mclk = ~mclk;

  vscp_top u_dut (
    .MCLK_I(mclk),
    .RST_B_I(rst_b),
    .SCK_I(sck),
    .SELECT_LOW_B_I(sel_b),
    .SDI_I(sdi),
    .PARALLEL_GAIN_CODE_I(pgain),
    .SDO_O(sdo),
    .SDO_OE_O(sdo_oe),
    .CH_I_ENABLE_O(ch_i),
    .CH_Q_ENABLE_O(ch_q),
    .AMP_BIAS_O(amp),
    .DRV_BIAS_O(drv),
    .LOW_INPUT_IMPEDANCE_SEL_O(lowz),
    .GAIN_FROM_SERIAL_O(src),
    .GAIN_DECODE_BYPASS_O(dec),
    .DEGLITCH_BYPASS_O(dgl),
    .STAGE_GAIN_CODE_O(stage)
  );

  vscp_host_model u_host (
    .sck_o(sck),
    .sel_b_o(sel_b),
    .sdi_o(sdi),
    .sdo_i(sdo_line),
    .sdo_oe_i(sdo_oe)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [4:0] ra, input logic [23:0] d,
    input logic [2:0] ca);
    logic [31:0] r;
    logic o;
    u_host.xfer({d, ra, ca}, r, o);
  endtask

  // Second frame rewrites register 0 so nothing else changes
  task automatic rd_chk(input logic [4:0] ra, input logic [23:0] exp);
    logic [31:0] r;
    logic o;
    wr(vscp_pkg::REG_RDADDR, {19'h0, ra}, vscp_pkg::CHIP_ADDR);
    u_host.xfer({19'h0, ra, vscp_pkg::REG_RDADDR, vscp_pkg::CHIP_ADDR},
      r, o);
    check(32'(o), 32'h1);
    check(r, {exp, ra, vscp_pkg::CHIP_ADDR});
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (60000) @(posedge mclk);
    bad_count++;
    $display("BAD at %0t: run did not complete", $time);
    conclude();
  end

  initial
  begin
    rst_b = 1'b0;
    pgain = 7'h00;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    check(32'(sdo_oe), 32'h0);
    check(32'({ch_q, ch_i}), 32'h3);
    check(32'(cfg), 32'h15);
    check(32'(stage), 32'h0);
    rd_chk(vscp_pkg::REG_ENABLE, 24'h3);
    rd_chk(vscp_pkg::REG_SETTINGS, 24'h15);
    wr(vscp_pkg::REG_ENABLE, 24'hfffffe, vscp_pkg::CHIP_ADDR);
    check(32'({ch_q, ch_i}), 32'h2);
    rd_chk(vscp_pkg::REG_ENABLE, 24'h2);
    foreach (set_tbl[k])
    begin
      wr(vscp_pkg::REG_SETTINGS, {16'hffff, set_tbl[k]}, vscp_pkg::CHIP_ADDR);
      check(32'(cfg), 32'({set_tbl[k][7], set_tbl[k][6] & set_tbl[k][5],
        set_tbl[k][5:0]}));
      rd_chk(vscp_pkg::REG_SETTINGS, {16'h0, set_tbl[k]});
    end
    // Gain source and decode bypass
    wr(vscp_pkg::REG_GAIN, 24'h0001ab, vscp_pkg::CHIP_ADDR);
    rd_chk(vscp_pkg::REG_GAIN, 24'h0001ab);
    rd_chk(5'h04, 24'h000000);
    wr(vscp_pkg::REG_SETTINGS, 24'h20, vscp_pkg::CHIP_ADDR);
    check(32'(stage), 32'h02b);
    wr(vscp_pkg::REG_SETTINGS, 24'h60, vscp_pkg::CHIP_ADDR);
    check(32'(stage), 32'h1ab);
    @(posedge mclk);
    pgain <= 7'h55;
    wr(vscp_pkg::REG_SETTINGS, 24'h00, vscp_pkg::CHIP_ADDR);
    check(32'(stage), 32'h055);
    // Pin latency with and without the stability filter
    @(posedge mclk);
    pgain <= 7'h11;
    repeat (3) @(posedge mclk);
    #1;
    check(32'(stage), 32'h055);
    @(posedge mclk);
    #1;
    check(32'(stage), 32'h011);
    wr(vscp_pkg::REG_SETTINGS, 24'h80, vscp_pkg::CHIP_ADDR);
    @(posedge mclk);
    pgain <= 7'h22;
    repeat (3) @(posedge mclk);
    #1;
    check(32'(stage), 32'h022);
    // Incoming bits of a read frame are written too
    wr(vscp_pkg::REG_RDADDR, {19'h0, vscp_pkg::REG_SETTINGS},
      vscp_pkg::CHIP_ADDR);
    u_host.xfer({24'h1, vscp_pkg::REG_ENABLE, vscp_pkg::CHIP_ADDR}, w, oe);
    check(w, {24'h80, vscp_pkg::REG_SETTINGS, vscp_pkg::CHIP_ADDR});
    check(32'({ch_q, ch_i}), 32'h1);
    // Foreign chip address: no write, pin not driven next frame
    wr(vscp_pkg::REG_ENABLE, 24'h3, 3'h5);
    check(32'({ch_q, ch_i}), 32'h1);
    u_host.xfer({19'h0, vscp_pkg::REG_ENABLE, vscp_pkg::REG_RDADDR,
      vscp_pkg::CHIP_ADDR}, w, oe);
    check(32'(oe), 32'h0);
    // Soft reset with another write between arm and fire
    wr(vscp_pkg::REG_RDADDR, 24'h20, vscp_pkg::CHIP_ADDR);
    wr(vscp_pkg::REG_SETTINGS, 24'hff, vscp_pkg::CHIP_ADDR);
    wr(vscp_pkg::REG_RDADDR, 24'h00, vscp_pkg::CHIP_ADDR);
    check(32'({ch_q, ch_i}), 32'h3);
    check(32'(cfg), 32'h15);
    rd_chk(vscp_pkg::REG_SETTINGS, 24'h15);
    // Reset in mid-run restores the register defaults
    wr(vscp_pkg::REG_ENABLE, 24'h0, vscp_pkg::CHIP_ADDR);
    wr(vscp_pkg::REG_SETTINGS, 24'hff, vscp_pkg::CHIP_ADDR);
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    check(32'({ch_q, ch_i}), 32'h3);
    check(32'(cfg), 32'h15);
    rd_chk(vscp_pkg::REG_SETTINGS, 24'h15);
    conclude();
  end
endmodule
`default_nettype wire
